// ==== rtl/ihpd_pkg.sv ====
// Package of constants for the ISA/PCMCIA host pin decode block
package ihpd_pkg;

  // ---------------------------------------------------------------------------
  // Bus widths and address fields
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned IO_DEC_LO     = 4;
  localparam int unsigned IO_DEC_HI     = 15;
  localparam int unsigned IO_DEC_W      = IO_DEC_HI - IO_DEC_LO + 1;
  localparam int unsigned IO_OFS_W      = IO_DEC_LO;
  localparam int unsigned PIN_A10       = 10;
  localparam int unsigned PIN_A11       = 11;
  localparam int unsigned PIN_A15       = 15;
  localparam int unsigned PIN_A19       = 19;
  localparam int unsigned ROM_DEC_LO    = 14;
  localparam int unsigned ROM_DEC_W     = ADDR_W - ROM_DEC_LO;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RST_MIN_NS    = 100;
  // Least time rounds up to whole cycles
  localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RST_CNT_W     = $clog2(RST_MIN_CYC + 1);

  // ---------------------------------------------------------------------------
  // Host personality
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IHPD_MODE_ISA    = 2'h1,
    IHPD_MODE_PCMCIA = 2'h2
  } ihpd_mode_e;

endpackage : ihpd_pkg

// ==== rtl/ihpd_reset_filter.sv ====
// Reset glitch filter: reset counts only after a minimum high time
`timescale 1ns/1ps
module ihpd_reset_filter
  import ihpd_pkg::*;
#(
  parameter int unsigned MIN_CYC = RST_MIN_CYC
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  output logic      rst_filt_out,
  output logic      rst_end_out
);
  import ihpd_pkg::*;

  // One raw sample per edge; a full window means reset has held long enough
  logic [MIN_CYC-1:0] hist_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  if (MIN_CYC < 1) begin : g_chk
    $error("ihpd_reset_filter: MIN_CYC must be at least one");
  end

  // Shift in one raw sample per edge. A shift register rather than a counter:
  // it needs no reset of its own and settles from any power-up value, at the
  // cost of one flop per cycle of window; a short pulse never fills it
  always_ff @(posedge clock_in) begin
    hist_r <= MIN_CYC'({hist_r, rst_in});
  end

  // Filtered reset holds until the raw input drops
  assign rst_filt_out = &hist_r;
  assign rst_end_out  = rst_filt_out && !rst_in; // Release edge, one cycle

endmodule // ihpd_reset_filter

// ==== rtl/ihpd_host_pins.sv ====
// Host pin decode for ISA and PCMCIA personalities
`timescale 1ns/1ps
module ihpd_host_pins
  import ihpd_pkg::*;
#(
  parameter int unsigned RST_CYC  = RST_MIN_CYC,
  parameter logic [ROM_DEC_W-1:0] ROM_BASE = '1
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  // Strap / boot ROM select pin
  input  wire logic                  strap_pin_in,
  output logic                       strap_pin_out,
  output logic                       strap_pin_oe_out,
  // Shared address pins; bits 10, 11 become flash outputs in PCMCIA mode
  input  wire logic [ihpd_pkg::ADDR_W-1:0] addr_in,
  output logic                       flash_write_strobe_out,
  output logic                       flash_chip_select_out,
  output logic                       flash_pins_oe_out,
  input  wire logic                  aen_attr_n_in,
  input  wire logic                  sbhe_ce2_n_in,
  input  wire logic                  ale_we_n_in,
  input  wire logic                  io_rd_n_in,
  input  wire logic                  io_wr_n_in,
  input  wire logic                  mem_rd_oe_n_in,
  // Core side
  input  wire logic                  config_option_bit2_in,
  input  wire logic                  config_option_bit0_in,
  input  wire logic                  bus16_mode_in,
  input  wire logic [ihpd_pkg::BYTE_W-1:0] io_base_hi_in,
  input  wire logic                  core_wait_in,
  input  wire logic [ihpd_pkg::DATA_W-1:0] core_rd_data_in,
  output logic [ihpd_pkg::DATA_W-1:0] core_wr_data_out,
  output logic [ihpd_pkg::IO_OFS_W-1:0] core_offset_out,
  output logic                       core_sel_out,
  output logic                       core_rd_out,
  output logic                       core_wr_out,
  output logic [1:0]                 core_lane_out,
  output logic                       pcmcia_mode_out,
  // Open-drain ready/wait and 16-bit indication
  output logic                       ready_wait_oe_out,
  output logic                       io_16bit_indication_oe_out,
  // Data bus
  input  wire logic [ihpd_pkg::DATA_W-1:0] data_in,
  output logic [ihpd_pkg::DATA_W-1:0] data_out,
  output logic                       data_oe_out
);
  import ihpd_pkg::*;

  logic       rst_filt;
  logic       rst_end;
  ihpd_mode_e mode_r;
  logic       pcm;
  logic       sel_nxt;
  logic       even_sel;
  logic       odd_sel;
  logic [DATA_W-1:0] rd_data_r;
  logic       rd_act_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  if (ADDR_W != 20 || DATA_W != 2 * BYTE_W) begin : g_chk
    $error("ihpd_host_pins: bus widths not supported");
  end

  // The filter needs a window of at least one edge to tell a glitch apart
  if (RST_CYC < 1) begin : g_chk_rst
    $error("ihpd_host_pins: RST_CYC must be at least one");
  end

  // ---------------------------------------------------------------------------
  // Reset filter and personality latch
  // ---------------------------------------------------------------------------
  ihpd_reset_filter #(
    .MIN_CYC      (RST_CYC)
  ) u_rst (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .rst_filt_out (rst_filt),
    .rst_end_out  (rst_end)
  );

  // Strap caught only at reset release; held thereafter, so later pin
  // activity (it is our own ROM select then) cannot flip the personality
  // While reset is filtered the pin enables are low, so the strap shows the board level
  always_ff @(posedge clock_in) begin
    if (rst_end) begin
      mode_r <= strap_pin_in ? IHPD_MODE_ISA : IHPD_MODE_PCMCIA;
    end else if (rst_filt) begin
      mode_r <= IHPD_MODE_ISA;
    end
  end

  assign pcm             = (mode_r == IHPD_MODE_PCMCIA);
  assign pcmcia_mode_out = pcm;

  // Address decode helper shared by ISA I/O match and 16-bit indication
  function automatic logic isa_io_hit(input logic [ADDR_W-1:0] a, input logic aen_n,
                                      input logic [BYTE_W-1:0] base);
    // Low byte of base is implicitly zero; bits 4..15 compare against base
    isa_io_hit = !aen_n && (a[IO_DEC_HI:IO_DEC_LO] == {base, 4'h0})
                 && (a[ADDR_W-1:IO_DEC_HI+1] == '0);
  endfunction

  // ---------------------------------------------------------------------------
  // Selects
  // ---------------------------------------------------------------------------
  // PCMCIA: CE1 picks the even byte, CE2 the odd byte; attr/IO select must
  // be low for I/O, and A4..A15 are not looked at
  assign even_sel = pcm ? !addr_in[PIN_A19] : !sbhe_ce2_n_in || !addr_in[0];
  assign odd_sel  = pcm ? !sbhe_ce2_n_in
                        : (!sbhe_ce2_n_in || addr_in[0]);

  // In ISA mode the AEN qualifier lives inside the shared helper
  always_comb begin
    if (pcm) begin
      sel_nxt = !aen_attr_n_in && (even_sel || odd_sel);
    end else begin
      sel_nxt = isa_io_hit(addr_in, aen_attr_n_in, io_base_hi_in);
    end
  end

  // Byte lanes: bit0 low byte, bit1 high byte
  // PCMCIA lanes come from the card enables, ISA lanes from SBHE and A0
  always_comb begin
    if (pcm) begin
      core_lane_out = {odd_sel, !addr_in[PIN_A19]};
    end else begin
      core_lane_out = {!sbhe_ce2_n_in, !addr_in[0]};
    end
  end

  // Core strobes follow the pins combinationally so the core answers in the
  // same cycle; the pin outputs below trail by one edge, save the data enable, which drops at once with the read strobe
  assign core_sel_out     = sel_nxt;
  assign core_rd_out      = sel_nxt && !io_rd_n_in;
  assign core_wr_out      = sel_nxt && !io_wr_n_in;
  assign core_offset_out  = addr_in[IO_OFS_W-1:0];
  assign core_wr_data_out = data_in;

  // ---------------------------------------------------------------------------
  // Boot ROM select and flash pins
  // ---------------------------------------------------------------------------
  // ROM select is registered; the pin stays an input until reset has ended
  always_ff @(posedge clock_in) begin
    if (rst_filt) begin
      strap_pin_out    <= 1'b1;
      strap_pin_oe_out <= 1'b0;
    end else begin
      strap_pin_oe_out <= !pcm;
      strap_pin_out    <= !(!pcm && !mem_rd_oe_n_in
                            && addr_in[ADDR_W-1:ROM_DEC_LO] == ROM_BASE);
    end
  end

  // Flash strobes are registered so a glitch on the host strobes never
  // reaches the flash part, at the price of one cycle of lag
  always_ff @(posedge clock_in) begin
    if (rst_filt) begin
      flash_write_strobe_out <= 1'b1;
      flash_chip_select_out  <= 1'b1;
      flash_pins_oe_out      <= 1'b0;
    end else begin
      flash_pins_oe_out      <= pcm; // ISA: these pins stay address inputs
      flash_write_strobe_out <= !(pcm && !ale_we_n_in && config_option_bit2_in);
      flash_chip_select_out  <= !(pcm && !aen_attr_n_in && !addr_in[PIN_A19]
                                  && !addr_in[PIN_A15]);
    end
  end

  // ---------------------------------------------------------------------------
  // Ready/wait and 16-bit indication (open drain, enable pulls low)
  // ---------------------------------------------------------------------------
  // Wait is pulled only inside a selected I/O strobe; outside one the line
  // returns to its pull-up, so a stuck core cannot hang unrelated cycles
  always_ff @(posedge clock_in) begin
    if (rst_filt) begin
      ready_wait_oe_out          <= 1'b0;
      io_16bit_indication_oe_out <= 1'b0;
    end else begin
      ready_wait_oe_out <= core_wait_in && sel_nxt
                           && (!io_rd_n_in || !io_wr_n_in);
      io_16bit_indication_oe_out <= bus16_mode_in &&
        (pcm ? (config_option_bit0_in && !aen_attr_n_in)
             : isa_io_hit(addr_in, aen_attr_n_in, io_base_hi_in));
    end
  end

  // ---------------------------------------------------------------------------
  // Data bus: driven only during our own read cycles
  // ---------------------------------------------------------------------------
  // The read flop gates the enable: the bus is driven only once the core has
  // seen a selected read, and is let go as soon as the host raises its strobe
  always_ff @(posedge clock_in) begin
    if (rst_filt) begin
      rd_act_r  <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_act_r  <= core_rd_out;
      rd_data_r <= core_rd_data_in;
    end
  end

  assign data_out    = rd_data_r;
  assign data_oe_out = rd_act_r && !io_rd_n_in;

endmodule // ihpd_host_pins

// ==== tb/ihpd_host_pins_checker.sv ====
// Checker of the host pin decode ports, bound to the block
`timescale 1ns/1ps
module ihpd_host_pins_checker
  import ihpd_pkg::*;
#(
  parameter logic [ROM_DEC_W-1:0] ROM_BASE = '1
) (
  input wire logic                         clock_in,
  input wire logic                         rst_in,
  input wire logic [ihpd_pkg::ADDR_W-1:0]  addr_in,
  input wire logic                         aen_attr_n_in,
  input wire logic                         sbhe_ce2_n_in,
  input wire logic                         ale_we_n_in,
  input wire logic                         io_rd_n_in,
  input wire logic                         mem_rd_oe_n_in,
  input wire logic                         config_option_bit2_in,
  input wire logic                         core_wait_in,
  input wire logic                         core_sel_out,
  input wire logic [1:0]                   core_lane_out,
  input wire logic                         pcmcia_mode_out,
  input wire logic                         strap_pin_out,
  input wire logic                         flash_write_strobe_out,
  input wire logic                         flash_chip_select_out,
  input wire logic                         ready_wait_oe_out,
  input wire logic                         data_oe_out
);
  // ---------------------------------------------------------------------------
  // Pin relations; raw reset disables, since the filter lags it
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  flash_we_a: assert property (
    pcmcia_mode_out |=> flash_write_strobe_out == $past(ale_we_n_in || !config_option_bit2_in))
    else $error("flash write strobe wrong");
  flash_cs_a: assert property (
    pcmcia_mode_out |=> flash_chip_select_out == $past(aen_attr_n_in || addr_in[PIN_A19] || addr_in[PIN_A15]))
    else $error("flash chip select wrong");
  rom_sel_a: assert property (
    !pcmcia_mode_out && !mem_rd_oe_n_in && addr_in[ADDR_W-1:ROM_DEC_LO] == ROM_BASE |=> !strap_pin_out)
    else $error("boot ROM select missing");
  isa_aen_a: assert property (!pcmcia_mode_out && aen_attr_n_in |-> !core_sel_out)
    else $error("select while AEN high");
  read_answer_a: assert property (core_sel_out && !io_rd_n_in ##1 !io_rd_n_in |-> data_oe_out)
    else $error("read data not driven");
  wait_release_a: assert property (!core_wait_in |=> !ready_wait_oe_out)
    else $error("wait held without cause");
  mode_hold_a: assert property ((!rst_in) [*3] |-> $stable(pcmcia_mode_out))
    else $error("mode changed outside reset");
  upper_lane_a: assert property (core_sel_out |-> core_lane_out[1] == !sbhe_ce2_n_in)
    else $error("upper lane steering wrong");
  cov_read: cover property (core_sel_out && !io_rd_n_in ##1 data_oe_out);
  cov_flash: cover property (pcmcia_mode_out && !flash_chip_select_out);
  cov_rom: cover property (!pcmcia_mode_out && !strap_pin_out);
endmodule // ihpd_host_pins_checker

bind ihpd_host_pins ihpd_host_pins_checker #(.ROM_BASE(ROM_BASE)) u_chk (
  .clock_in, .rst_in, .addr_in, .aen_attr_n_in, .sbhe_ce2_n_in, .ale_we_n_in, .io_rd_n_in,
  .mem_rd_oe_n_in, .config_option_bit2_in, .core_wait_in, .core_sel_out, .core_lane_out,
  .pcmcia_mode_out, .strap_pin_out, .flash_write_strobe_out, .flash_chip_select_out,
  .ready_wait_oe_out, .data_oe_out);

// ==== tb/ihpd_host_model.sv ====
// Host bus controller model driving the shared pins
`timescale 1ns/1ps
module ihpd_host_model
  import ihpd_pkg::*;
(
  input  wire logic                        clock_in,
  input  wire logic [ihpd_pkg::DATA_W-1:0] data_out,
  input  wire logic                        data_oe_out,
  output logic [ihpd_pkg::ADDR_W-1:0]      addr_out,
  output logic                             aen_n_out,
  output logic                             be_n_out,
  output logic [3:0]                       strobe_n_out,
  output logic [ihpd_pkg::DATA_W-1:0]      data_bus_out
);
  logic [DATA_W-1:0] wr_r;
  logic              drv_r;
  // Bus level: device, else host write data, else the weak pull-ups
  assign data_bus_out = data_oe_out ? data_out : (drv_r ? wr_r : '1);
  // Idle bus at time zero
  initial begin
    addr_out = '0;
    aen_n_out = 1'b1;
    be_n_out = 1'b1;
    strobe_n_out = 4'hF;
    drv_r = 1'b0;
    wr_r = '0;
  end
  // One cycle, strobes {we, io rd, io wr, mem rd}, launched off the falling edge
  task automatic cycle(input logic [3:0] st, input logic [ADDR_W-1:0] a,
                       input logic en_n, input logic hi_n, input logic [DATA_W-1:0] wd);
    @(negedge clock_in);
    addr_out <= a;
    aen_n_out <= en_n;
    be_n_out <= hi_n;
    strobe_n_out <= st;
    drv_r <= !st[1];
    wr_r <= wd;
  endtask
endmodule // ihpd_host_model

// ==== tb/ihpd_host_pins_tb.sv ====
// Testbench of the host pin decode block
`timescale 1ns/1ps
module ihpd_host_pins_tb import ihpd_pkg::*;;
  logic clock_in = 1'b0, rst_in = 1'b1, strap_drv = 1'b1, config_option_bit2_in = 1'b0;
  logic config_option_bit0_in = 1'b0, bus16_mode_in = 1'b1, core_wait_in = 1'b0;
  logic [BYTE_W-1:0] io_base_hi_in = 8'h03;
  logic [DATA_W-1:0] core_rd_data_in = 16'hA55A, data_in, data_out, core_wr_data_out;
  logic strap_pin_in, strap_pin_out, strap_pin_oe_out, flash_write_strobe_out, flash_chip_select_out;
  logic flash_pins_oe_out, core_sel_out, core_rd_out, core_wr_out, pcmcia_mode_out, ready_wait_oe_out;
  logic io_16bit_indication_oe_out, data_oe_out, aen_attr_n_in, sbhe_ce2_n_in;
  logic [ADDR_W-1:0] addr_in;
  logic [3:0] st;
  logic [IO_OFS_W-1:0] core_offset_out;
  logic [1:0] core_lane_out;
  int mismatches = 0, n_checks = 0;
  // Strap wire: device in ISA mode, else the board level
  assign strap_pin_in = strap_pin_oe_out ? strap_pin_out : strap_drv;
  always #2.5 clock_in = ~clock_in;
  // Short filter count keeps the glitch case brief
  ihpd_host_pins #(.RST_CYC(2)) DUT (
    .clock_in, .rst_in, .strap_pin_in, .strap_pin_out, .strap_pin_oe_out, .addr_in,
    .flash_write_strobe_out, .flash_chip_select_out, .flash_pins_oe_out, .aen_attr_n_in, .sbhe_ce2_n_in,
    .ale_we_n_in(st[3]), .io_rd_n_in(st[2]), .io_wr_n_in(st[1]), .mem_rd_oe_n_in(st[0]),
    .config_option_bit2_in, .config_option_bit0_in, .bus16_mode_in, .io_base_hi_in, .core_wait_in,
    .core_rd_data_in, .core_wr_data_out, .core_offset_out, .core_sel_out, .core_rd_out, .core_wr_out,
    .core_lane_out, .pcmcia_mode_out, .ready_wait_oe_out, .io_16bit_indication_oe_out,
    .data_in, .data_out, .data_oe_out);
  ihpd_host_model P (.clock_in, .data_out, .data_oe_out, .addr_out(addr_in), .aen_n_out(aen_attr_n_in),
    .be_n_out(sbhe_ce2_n_in), .strobe_n_out(st), .data_bus_out(data_in));
  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_isa();
    chk({pcmcia_mode_out, flash_pins_oe_out}, 2'b00);
    P.cycle(4'b1011, 20'h00302, 1'b0, 1'b0, '1);
    #1 chk(core_sel_out, 1'b1);
    chk({core_lane_out, core_offset_out}, 6'h32);
    chk({core_rd_out, core_wr_out}, 2'b10);
    @(posedge clock_in) #1 chk(data_in, 16'hA55A);
    chk(io_16bit_indication_oe_out, 1'b1);
    P.cycle(4'b1011, 20'h00302, 1'b1, 1'b1, '1);
    #1 chk(core_sel_out, 1'b0);
    P.cycle(4'b1011, 20'h10302, 1'b0, 1'b0, '1);
    #1 chk(core_sel_out, 1'b0);
    P.cycle(4'b1101, 20'h00304, 1'b0, 1'b1, 16'h1234);
    #1 chk(core_wr_data_out, 16'h1234);
    chk({core_rd_out, core_wr_out}, 2'b01);
    P.cycle(4'b1110, 20'hFC123, 1'b0, 1'b1, '1);
    @(posedge clock_in) #1 chk(strap_pin_out, 1'b0);
    // Wait is pulled inside a selected I/O read and let go once the core drops it
    P.cycle(4'b1011, 20'h00302, 1'b0, 1'b0, '1);
    core_wait_in = 1'b1;
    @(posedge clock_in) #1 chk(ready_wait_oe_out, 1'b1);
    @(negedge clock_in) core_wait_in = 1'b0;
    @(posedge clock_in) #1 chk(ready_wait_oe_out, 1'b0);
    // Idle bus, so no read stands across the next reset
    P.cycle(4'hF, 20'h00000, 1'b1, 1'b1, '1);
    $display("test isa done");
  endtask
  // A pulse shorter than the filter must not relatch the mode
  task automatic t_glitch();
    @(negedge clock_in) strap_drv = 1'b0;
    rst_in = 1'b1;
    @(negedge clock_in) rst_in = 1'b0;
    // A filter that took the pulse would have dropped the pin enable by now
    @(negedge clock_in) chk({pcmcia_mode_out, strap_pin_oe_out}, 2'b01);
    repeat (2) @(negedge clock_in);
    chk({pcmcia_mode_out, strap_pin_oe_out}, 2'b01);
    strap_drv = 1'b1;
    $display("test glitch done");
  endtask
  task automatic t_pcmcia();
    @(negedge clock_in) strap_drv = 1'b0;
    rst_in = 1'b1;
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    strap_drv = 1'b1;
    config_option_bit2_in = 1'b1;
    P.cycle(4'b0111, 20'h08000, 1'b1, 1'b1, '1);
    @(posedge clock_in) #1 chk(pcmcia_mode_out, 1'b1);
    chk({flash_write_strobe_out, flash_chip_select_out}, 2'b01);
    chk(flash_pins_oe_out, 1'b1);
    @(negedge clock_in) config_option_bit2_in = 1'b0;
    @(posedge clock_in) #1 chk(flash_write_strobe_out, 1'b1);
    P.cycle(4'b1111, 20'h00000, 1'b0, 1'b1, '1);
    @(posedge clock_in) #1 chk(flash_chip_select_out, 1'b0);
    P.cycle(4'b1011, 20'h0ABC5, 1'b0, 1'b0, '1);
    #1 chk(core_sel_out, 1'b1);
    chk({core_lane_out[1], core_offset_out}, 5'h15);
    P.cycle(4'b1011, 20'h0ABC5, 1'b1, 1'b0, '1);
    #1 chk(core_sel_out, 1'b0);
    $display("test pcmcia done");
  endtask
  // Main sequence: five reset cycles, then the scenarios
  initial begin
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    t_isa();
    t_glitch();
    t_pcmcia();
    report_and_stop();
  end
  // Watchdog: the run needs well under a microsecond
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule // ihpd_host_pins_tb
